// ==== design/ssrs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssrs_top
    import ssrs_pkg::*;
#(
    parameter ssrs_pkg::ssrs_opt_t OPTION = ssrs_pkg::SSRS_OPT_LOW_MR_WD,
    parameter longint unsigned HOLD_TICKS = ssrs_pkg::HOLD_CYC,
    parameter longint unsigned WDOG_TICKS = ssrs_pkg::WDOG_CYC
) (
    input wire logic mclk, // 10 MHz timebase
    input wire logic rst_n, // Async reset, active low
    input wire ssrs_pkg::ssrs_in_t pins_in, // Supply flag, manual reset, watchdog
    output var ssrs_pkg::ssrs_out_t rst_out // Reset outputs
);
    import ssrs_pkg::*;

    localparam bit HAS_MR = (OPTION != SSRS_OPT_BOTH_WD);
    localparam bit HAS_WD = (OPTION != SSRS_OPT_BOTH_MR);
    localparam bit HAS_HI = (OPTION != SSRS_OPT_LOW_MR_WD);

    logic [1:0] rsync_q;
    logic srst_n;
    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign srst_n = rsync_q[1];

    // Pin synchronisers, three flops each; only stages 2 and 3 are read
    logic [2:0] sup_q, mr_q, wd_q, wdd_q;
    logic [2:0] sup_d, mr_d, wd_d, wdd_d;
    logic mr_pin;
    // An option without the manual reset ties its input high
    assign mr_pin = HAS_MR ? pins_in.manual_reset_in_n : 1'b1;
    always_comb begin
        sup_d = {sup_q[1:0], pins_in.supply_ok};
        mr_d = {mr_q[1:0], mr_pin};
        wd_d = {wd_q[1:0], pins_in.watchdog_kick_input};
        wdd_d = {wdd_q[1:0], pins_in.watchdog_kick_driven};
    end
    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            sup_q <= 3'h0;
            mr_q <= SYNC_RST;
            wd_q <= 3'h0;
            wdd_q <= 3'h0;
        end else begin
            sup_q <= sup_d;
            mr_q <= mr_d;
            wd_q <= wd_d;
            wdd_q <= wdd_d;
        end
    end

    // Filtered levels change only once stages 2 and 3 agree
    logic sup_q2, mr_q2, wd_q2, wdd_q2;
    logic sup_f_d, mr_f_d, wd_f_d, wdd_f_d;
    always_comb begin
        sup_f_d = (sup_q[1] == sup_q[2]) ? sup_q[2] : sup_q2;
        mr_f_d = (mr_q[1] == mr_q[2]) ? mr_q[2] : mr_q2;
        wd_f_d = (wd_q[1] == wd_q[2]) ? wd_q[2] : wd_q2;
        wdd_f_d = (wdd_q[1] == wdd_q[2]) ? wdd_q[2] : wdd_q2;
    end
    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            sup_q2 <= 1'b0;
            mr_q2 <= 1'b1;
            wd_q2 <= 1'b0;
            wdd_q2 <= 1'b0;
        end else begin
            sup_q2 <= sup_f_d;
            mr_q2 <= mr_f_d;
            wd_q2 <= wd_f_d;
            wdd_q2 <= wdd_f_d;
        end
    end

    // Watchdog: count since last edge; wide to hold long timeouts
    logic [39:0] wd_cnt_q, wd_cnt_d;
    logic wd_last_q, wd_last_d;
    logic wd_trip;
    logic wd_on;
    logic in_reset;
    assign wd_on = HAS_WD && wdd_q2;
    always_comb begin
        wd_last_d = wd_q2;
        wd_cnt_d = wd_cnt_q;
        wd_trip = 1'b0;
        if (!wd_on || in_reset || (wd_q2 != wd_last_q)) begin
            wd_cnt_d = 40'h0;
        end else if (wd_cnt_q >= 40'(WDOG_TICKS - 1)) begin
            wd_trip = 1'b1;
            wd_cnt_d = 40'h0;
        end else begin
            wd_cnt_d = wd_cnt_q + 40'h1;
        end
    end
    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            wd_cnt_q <= 40'h0;
            wd_last_q <= 1'b0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
            wd_last_q <= wd_last_d;
        end
    end

    // Reset sequencer
    typedef enum logic [1:0] {
        SSRS_ST_LOW_SUPPLY,
        SSRS_ST_HOLD,
        SSRS_ST_RUN
    } ssrs_state_t;
    ssrs_state_t st_q, st_d;
    logic [39:0] hold_q, hold_d;
    logic mr_act;
    assign mr_act = HAS_MR && !mr_q2;
    assign in_reset = (st_q != SSRS_ST_RUN);
    always_comb begin
        st_d = st_q;
        hold_d = hold_q;
        unique case (st_q)
            SSRS_ST_LOW_SUPPLY: begin
                hold_d = 40'h0;
                if (sup_q2) begin
                    st_d = SSRS_ST_HOLD;
                end
            end
            SSRS_ST_HOLD: begin
                if (mr_act) begin
                    hold_d = 40'h0; // Held button keeps reset asserted
                end else if (hold_q >= 40'(HOLD_TICKS - 1)) begin
                    st_d = SSRS_ST_RUN;
                end else begin
                    hold_d = hold_q + 40'h1;
                end
            end
            SSRS_ST_RUN: begin
                hold_d = 40'h0;
                if (mr_act || wd_trip) begin
                    st_d = SSRS_ST_HOLD;
                end
            end
        endcase
        // Supply loss overrides everything
        if (!sup_q2) begin
            st_d = SSRS_ST_LOW_SUPPLY;
            hold_d = 40'h0;
        end
    end
    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            st_q <= SSRS_ST_LOW_SUPPLY;
            hold_q <= 40'h0;
        end else begin
            st_q <= st_d;
            hold_q <= hold_d;
        end
    end

    // Outputs registered; high output held low outside reset when the option lacks it
    ssrs_out_t out_d, out_q;
    always_comb begin
        out_d.reset_n = (st_d == SSRS_ST_RUN);
        out_d.reset = HAS_HI ? (st_d != SSRS_ST_RUN) : 1'b0;
    end
    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            out_q <= '{reset_n: 1'b0, reset: 1'b1};
        end else begin
            out_q <= out_d;
        end
    end
    assign rst_out = out_q;
endmodule : ssrs_top
`default_nettype wire

// ==== pkg/ssrs_pkg.sv ====
package ssrs_pkg;
    // Least reset hold time in milliseconds
    localparam int unsigned HOLD_MS = 140;
    // Clock rate in hertz
    localparam int unsigned CLK_HZ = 10_000_000;
    // Least hold rounds up to whole cycles
    localparam longint unsigned HOLD_CYC = (longint'(HOLD_MS) * CLK_HZ + 999) / 1000;
    // Watchdog timeout in milliseconds (plain default)
    localparam int unsigned WDOG_MS = 1600;
    localparam longint unsigned WDOG_CYC = (longint'(WDOG_MS) * CLK_HZ) / 1000;
    // Reset value of the manual reset synchroniser stages
    localparam logic [2:0] SYNC_RST = 3'h7;

    // Build options
    typedef enum logic [1:0] {
        SSRS_OPT_LOW_MR_WD,
        SSRS_OPT_BOTH_WD,
        SSRS_OPT_BOTH_MR
    } ssrs_opt_t;

    // Pins from the host side, already split into four signals
    typedef struct packed {
        logic supply_ok;
        logic manual_reset_in_n;
        logic watchdog_kick_input;
        logic watchdog_kick_driven;
    } ssrs_in_t;

    // Reset outputs as a pair
    typedef struct packed {
        logic reset_n;
        logic reset;
    } ssrs_out_t;
endpackage : ssrs_pkg

// ==== tb/ssrs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssrs_host (
    input wire logic mclk, // Clock
    input wire logic run, // Keep kicking
    input wire logic en, // Drive the pin
    output logic kick, // Watchdog level
    output logic driven // Pin driven flag
);
    int gap = 10;
    initial kick = 1'b0;
    assign driven = en;
    // A released pin wanders, so it must not look like a kick
    always @(negedge mclk) begin
        if (!en) begin
            kick <= !kick;
        end else if (run) begin
            gap = gap - 1;
            if (gap == 0) begin
                kick <= !kick;
                gap = 5 + $urandom % 30;
            end
        end
    end
endmodule : ssrs_host
`default_nettype wire

// ==== tb/ssrs_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssrs_chk
    import ssrs_pkg::*;
#(
    parameter longint unsigned HOLD_TICKS = 20,
    parameter longint unsigned WDOG_TICKS = 50
) (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Async reset
    input wire ssrs_pkg::ssrs_in_t pins_in, // Pins
    input wire ssrs_pkg::ssrs_out_t rst_out // Outputs
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] idle_q;
    logic kick_q;
    // Cycles since the last kick edge while supervised and running
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idle_q <= 8'h00;
            kick_q <= 1'b0;
        end else begin
            kick_q <= pins_in.watchdog_kick_input;
            if (!rst_out.reset_n || !pins_in.watchdog_kick_driven
                || kick_q != pins_in.watchdog_kick_input) begin
                idle_q <= 8'h00;
            end else begin
                idle_q <= idle_q + 8'h01;
            end
        end
    end
    a_supply_low_reset: assert property (!pins_in.supply_ok [*8] |-> !rst_out.reset_n)
        else $error("reset released with supply low");
    a_hold_supply: assert property ($rose(rst_out.reset_n) |-> $past(pins_in.supply_ok, HOLD_TICKS))
        else $error("release before hold after supply");
    a_hold_min_time: assert property ($rose(rst_out.reset_n) |-> !$past(rst_out.reset_n, HOLD_TICKS))
        else $error("reset shorter than hold");
    a_hold_manual: assert property ($rose(rst_out.reset_n) |-> $past(pins_in.manual_reset_in_n, HOLD_TICKS))
        else $error("release before hold after manual");
    a_manual_low_reset: assert property (!pins_in.manual_reset_in_n [*8] |-> !rst_out.reset_n)
        else $error("manual low ignored");
    a_wdog_idle_bound: assert property (idle_q <= WDOG_TICKS + 8)
        else $error("watchdog timeout missed");
    a_reset_min_hold: assert property ($fell(rst_out.reset_n) |=> !rst_out.reset_n [*8])
        else $error("reset pulse too short");
    a_high_out_unused: assert property (rst_out.reset_n |-> !rst_out.reset)
        else $error("high output active in low option");
endmodule : ssrs_chk
bind ssrs_top ssrs_chk #(.HOLD_TICKS(HOLD_TICKS), .WDOG_TICKS(WDOG_TICKS)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .pins_in(pins_in), .rst_out(rst_out));
`default_nettype wire

// ==== tb/tb_supply_reset_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_supply_reset_supervisor;
    import ssrs_pkg::*;
    localparam int HT = 20;
    localparam int WT = 50;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sup = 1'b0;
    logic mr_n = 1'b1;
    logic run = 1'b0;
    logic en = 1'b0;
    logic kick;
    logic drv;
    ssrs_in_t pins_in;
    ssrs_out_t rst_out;
    int err_count = 0;
    int tests_run = 0;
    int n;
    assign pins_in = '{sup, mr_n, kick, drv};
    ssrs_top #(.OPTION(SSRS_OPT_LOW_MR_WD), .HOLD_TICKS(HT), .WDOG_TICKS(WT)) DUT (
        .mclk(mclk), .rst_n(rst_n), .pins_in(pins_in), .rst_out(rst_out));
    ssrs_host u_host (.mclk(mclk), .run(run), .en(en), .kick(kick), .driven(drv));
    always #50 mclk = ~mclk;
    task automatic final_report;
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // Counts cycles until the low output reaches e, then checks the window
    task automatic wait_lvl(input logic e, input int lo, input int hi);
        n = 0;
        while (rst_out.reset_n !== e && n < 400) begin
            @(negedge mclk);
            n++;
        end
        `CHK("delay", 1'b1, n >= lo && n <= hi)
    endtask : wait_lvl
    task automatic hold(input int c, input logic e);
        repeat (c) begin
            @(negedge mclk);
            `CHK("level", e, rst_out.reset_n)
        end
    endtask : hold
    // Main sequence; the pushbutton rests high like its pull-up
    initial begin
        n = $urandom(39020);
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        hold(30, 1'b0);
        sup = 1'b1;
        wait_lvl(1'b1, HT, HT + 8);
        `CHK("high_out", 1'b0, rst_out.reset)
        $display("power_up done");
        mr_n = 1'b0;
        repeat (8 + $urandom % 10) @(negedge mclk);
        `CHK("manual", 1'b0, rst_out.reset_n)
        mr_n = 1'b1;
        wait_lvl(1'b1, HT, HT + 8);
        $display("manual done");
        en = 1'b1;
        run = 1'b1;
        hold(300, 1'b1);
        run = 1'b0;
        wait_lvl(1'b0, WT - 30, WT + 8);
        run = 1'b1;
        wait_lvl(1'b1, 1, HT + 8);
        $display("watchdog done");
        en = 1'b0;
        hold(200, 1'b1);
        $display("undriven done");
        sup = 1'b0;
        wait_lvl(1'b0, 1, 8);
        hold(50, 1'b0);
        sup = 1'b1;
        wait_lvl(1'b1, HT, HT + 8);
        $display("brownout done");
        // Mid-run reset must force outputs into reset at once
        rst_n = 1'b0;
        @(negedge mclk);
        `CHK("async_rst", 1'b0, rst_out.reset_n)
        rst_n = 1'b1;
        wait_lvl(1'b1, HT, HT + 10);
        $display("reset done");
        final_report;
    end
    // Hang guard, well beyond the expected run length
    initial begin
        #(3000 * 100);
        err_count++;
        final_report;
    end
endmodule : tb_supply_reset_supervisor
`default_nettype wire
